/* mrc_slave_end.sv */
`timescale 1ns/1ns
// Function
// - Execute only when computed CRC matches carried
// - Accumulator preset all ones per frame
// - Address byte folded first into low bits
// - Shift right, xor polynomial on carry
// - Eight shift steps per byte
// - Next byte folded in; remainder is checksum
// - Address 2, function 3 give D140
// - Master checks response CRC identically
// - Read up to sixteen registers, reject more
// - Read request and response field layout
// - Loopback echoes eight-byte frame byte for byte
// - Loopback test code and data echoed
// - Broadcast executed, never answered; here only cmdOk pulses, no read or loopback runs
// - Registers are always two bytes
module mrc_slave_end
    import mrc_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Link to master
    mrc_link_if.slave        link,
    // Own station address
    input  wire logic [7:0]  ownAddr,
    // Register read port, data one cycle after address
    output logic      [15:0] regAddr,
    input  wire logic [15:0] regData,
    // Frame reports
    output logic             cmdOk,
    output logic             crcBad
);

    //------------------------------------------------------------------
    // Types and state
    //------------------------------------------------------------------
    typedef enum logic [7:0] {
        ST_IDLE  = 8'b0000_0001,
        ST_ECHO  = 8'b0000_0010,
        ST_HEAD  = 8'b0000_0100,
        ST_FETCH = 8'b0000_1000,
        ST_HI    = 8'b0001_0000,
        ST_LO    = 8'b0010_0000,
        ST_CRCL  = 8'b0100_0000,
        ST_CRCH  = 8'b1000_0000
    } mrc_slv_st_t;

    mrc_slv_st_t stateQ;
    logic [7:0]  bufQ [0:7];
    logic [3:0]  cntQ;
    logic [15:0] crcQ;
    logic [15:0] crcPrevQ;
    logic [7:0]  prevByteQ;
    logic [3:0]  txIdxQ;
    logic [4:0]  qtyQ;
    logic [4:0]  regIdxQ;
    logic [15:0] regAddrQ;
    logic [7:0]  loByteQ;
    logic        excQ;
    logic [7:0]  excCodeQ;
    logic [15:0] txCrcQ;
    logic        txValidQ;
    logic [7:0]  txDataQ;
    logic        txLastQ;
    logic        cmdOkQ;
    logic        crcBadQ;

    //------------------------------------------------------------------
    // Frame decode at the last received byte
    //------------------------------------------------------------------
    logic        rxTake;
    logic        frameEnd;
    logic        crcMatch;
    logic        forUs;
    logic        isBcast;
    logic        lenOk;
    logic [15:0] qtyReq;
    logic        readOk;

    assign rxTake   = link.mValid && (stateQ == ST_IDLE);
    assign frameEnd = rxTake && link.mLast;
    // Carried check value arrives low byte then high byte
    assign crcMatch = (crcPrevQ == {link.mData, prevByteQ}) && (cntQ >= 4'h3);
    assign isBcast  = (bufQ[0] == ADDR_BCAST);
    assign forUs    = isBcast || (bufQ[0] == ownAddr);
    assign lenOk    = (cntQ == REQ_LAST_IDX);
    assign qtyReq   = {bufQ[4], bufQ[5]};
    assign readOk   = lenOk && (qtyReq != 16'h0000) && (qtyReq <= MAX_QTY);

    //------------------------------------------------------------------
    // Receive buffer and byte count
    //------------------------------------------------------------------
    // Byte count and previous byte, kept for decode and the check
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            cntQ      <= 4'h0;
            prevByteQ <= 8'h00;
        end
        else if (rxTake)
        begin
            prevByteQ <= link.mData;
            if (link.mLast)
                cntQ <= 4'h0;
            else if (cntQ != 4'hf)
                cntQ <= cntQ + 4'h1;
        end
    end

    // Storage array, no reset needed for data
    always_ff @(posedge core_clk)
    begin
        if (rxTake && (cntQ < BUF_DEPTH))
            bufQ[cntQ[2:0]] <= link.mData;
    end

    //------------------------------------------------------------------
    // Receive CRC accumulator
    //------------------------------------------------------------------
    // Preset at reset and after every frame; each byte but the last runs eight steps
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            crcQ     <= CRC_PRESET;
            crcPrevQ <= CRC_PRESET;
        end
        else if (frameEnd)
        begin
            crcQ     <= CRC_PRESET;
            crcPrevQ <= CRC_PRESET;
        end
        else if (rxTake)
        begin
            crcPrevQ <= crcQ;
            crcQ     <= mrc_crc_byte(crcQ, link.mData);
        end
    end

    //------------------------------------------------------------------
    // Response sequencer
    //------------------------------------------------------------------
    // Chooses the response kind and walks its bytes
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            stateQ   <= ST_IDLE;
            txIdxQ   <= 4'h0;
            qtyQ     <= 5'h00;
            regIdxQ  <= 5'h00;
            regAddrQ <= 16'h0000;
            excQ     <= 1'b0;
            excCodeQ <= 8'h00;
            loByteQ  <= 8'h00;
        end
        else
        begin
            case (stateQ)
                ST_IDLE:
                begin
                    txIdxQ  <= 4'h0;
                    regIdxQ <= 5'h00;
                    // Bad CRC, foreign or broadcast frames get no answer
                    if (frameEnd && crcMatch && forUs && !isBcast)
                    begin
                        qtyQ     <= qtyReq[4:0];
                        regAddrQ <= {bufQ[2], bufQ[3]};
                        if ((bufQ[1] == FN_LOOP) && lenOk)
                        begin
                            stateQ <= ST_ECHO;
                        end
                        else
                        begin
                            stateQ   <= ST_HEAD;
                            excQ     <= !((bufQ[1] == FN_READ) && readOk);
                            excCodeQ <= (bufQ[1] == FN_READ) ? ERR_QTY : ERR_FUNC;
                        end
                    end
                end
                ST_ECHO:
                begin
                    txIdxQ <= txIdxQ + 4'h1;
                    if (txIdxQ == REQ_LAST_IDX)
                        stateQ <= ST_IDLE;
                end
                ST_HEAD:
                begin
                    txIdxQ <= txIdxQ + 4'h1;
                    if (txIdxQ == HDR_LAST_IDX)
                        stateQ <= excQ ? ST_CRCL : ST_FETCH;
                end
                ST_FETCH:
                begin
                    stateQ <= ST_HI;
                end
                ST_HI:
                begin
                    loByteQ <= regData[7:0];
                    stateQ  <= ST_LO;
                end
                ST_LO:
                begin
                    if ((regIdxQ + 5'h01) == qtyQ)
                    begin
                        stateQ <= ST_CRCL;
                    end
                    else
                    begin
                        regIdxQ  <= regIdxQ + 5'h01;
                        regAddrQ <= regAddrQ + 16'h0001;
                        stateQ   <= ST_FETCH;
                    end
                end
                ST_CRCL:
                begin
                    stateQ <= ST_CRCH;
                end
                ST_CRCH:
                begin
                    stateQ <= ST_IDLE;
                end
                default:
                begin
                    stateQ <= ST_IDLE;
                end
            endcase
        end
    end

    //------------------------------------------------------------------
    // Transmit byte selection
    //------------------------------------------------------------------
    logic       sendNow;
    logic       sendCrc;
    logic       sendLast;
    logic [7:0] sendByte;

    // Picks the byte of the current state
    always_comb
    begin
        sendNow  = 1'b1;
        sendCrc  = 1'b1;
        sendLast = 1'b0;
        sendByte = 8'h00;
        case (stateQ)
            ST_ECHO:
            begin
                sendByte = bufQ[txIdxQ[2:0]];
                sendLast = (txIdxQ == REQ_LAST_IDX);
            end
            ST_HEAD:
            begin
                if (txIdxQ == 4'h0)
                    sendByte = bufQ[0];
                else if (txIdxQ == 4'h1)
                    sendByte = excQ ? (bufQ[1] | FN_EXC_BIT) : bufQ[1];
                else
                    sendByte = excQ ? excCodeQ : {2'b00, qtyQ, 1'b0};
            end
            ST_HI:
            begin
                sendByte = regData[15:8];
            end
            ST_LO:
            begin
                sendByte = loByteQ;
            end
            ST_CRCL:
            begin
                sendByte = txCrcQ[7:0];
                sendCrc  = 1'b0;
            end
            ST_CRCH:
            begin
                sendByte = txCrcQ[15:8];
                sendCrc  = 1'b0;
                sendLast = 1'b1;
            end
            default:
            begin
                sendNow = 1'b0;
                sendCrc = 1'b0;
            end
        endcase
    end

    // Transmit CRC, preset while idle
    always_ff @(posedge core_clk)
    begin
        if (rst || (stateQ == ST_IDLE))
            txCrcQ <= CRC_PRESET;
        else if (sendCrc)
            txCrcQ <= mrc_crc_byte(txCrcQ, sendByte);
    end

    // Registered link outputs
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            txValidQ <= 1'b0;
            txDataQ  <= 8'h00;
            txLastQ  <= 1'b0;
        end
        else
        begin
            txValidQ <= sendNow;
            txDataQ  <= sendNow ? sendByte : 8'h00;
            txLastQ  <= sendNow && sendLast;
        end
    end

    // Frame report pulses
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            cmdOkQ  <= 1'b0;
            crcBadQ <= 1'b0;
        end
        else
        begin
            cmdOkQ  <= frameEnd && crcMatch && forUs;
            crcBadQ <= frameEnd && !crcMatch;
        end
    end

    assign link.sValid = txValidQ;
    assign link.sData  = txDataQ;
    assign link.sLast  = txLastQ;
    assign regAddr     = regAddrQ;
    assign cmdOk       = cmdOkQ;
    assign crcBad      = crcBadQ;

endmodule : mrc_slave_end

/* mrc_pkg.sv */
//----------------------------------------------------------------------
// Shared constants for the RTU frame checker link
//----------------------------------------------------------------------
package mrc_pkg;

    // CRC engine
    localparam logic [15:0] CRC_PRESET   = 16'hffff;
    localparam logic [15:0] CRC_POLY     = 16'ha001;
    localparam logic [15:0] CRC_TEST_VEC = 16'hd140;
    localparam int          CRC_STEPS    = 8;

    // Frame fields
    localparam logic [7:0]  ADDR_BCAST   = 8'h00;
    localparam logic [7:0]  FN_READ      = 8'h03;
    localparam logic [7:0]  FN_LOOP      = 8'h08;
    localparam logic [7:0]  FN_EXC_BIT   = 8'h80;
    localparam logic [7:0]  ERR_FUNC     = 8'h01;
    localparam logic [7:0]  ERR_QTY      = 8'h03;
    localparam logic [15:0] MAX_QTY      = 16'h0010;
    localparam logic [3:0]  REQ_LAST_IDX = 4'h7;
    localparam logic [3:0]  BUF_DEPTH    = 4'h8;
    localparam logic [3:0]  HDR_LAST_IDX = 4'h2;
    localparam logic [3:0]  MST_DATA_END = 4'h5;

    // One CRC byte: fold the byte into the low bits, then eight shift steps
    function automatic logic [15:0] mrc_crc_byte(input logic [15:0] acc,
                                                 input logic [7:0]  dat);
        logic [15:0] c;
        c = acc ^ {8'h00, dat};
        for (int i = 0; i < CRC_STEPS; i++)
        begin
            if (c[0])
                c = (c >> 1) ^ CRC_POLY;
            else
                c = c >> 1;
        end
        return c;
    endfunction : mrc_crc_byte

endpackage : mrc_pkg

/* mrc_link_if.sv */
`timescale 1ns/1ns
//----------------------------------------------------------------------
// Byte link between bus master and slave
//----------------------------------------------------------------------
interface mrc_link_if;
    logic       mValid;  // Master byte strobe
    logic [7:0] mData;
    logic       mLast;   // Last byte of master frame
    logic       sValid;  // Slave byte strobe
    logic [7:0] sData;
    logic       sLast;   // Last byte of slave frame

    modport master (output mValid, mData, mLast, input sValid, sData, sLast);
    modport slave  (input mValid, mData, mLast, output sValid, sData, sLast);
endinterface : mrc_link_if

/* mrc_master_end.sv */
`timescale 1ns/1ns
module mrc_master_end
    import mrc_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Link to slave
    mrc_link_if.master       link,
    // Request port
    input  wire logic        reqGo,
    input  wire logic [7:0]  reqSlave,
    input  wire logic [7:0]  reqFunc,
    input  wire logic [15:0] reqWordA,
    input  wire logic [15:0] reqWordB,
    output logic             busy,
    // Response port
    output logic             respByteValid,
    output logic [7:0]       respByte,
    output logic             respDone,
    output logic             respOk,
    output logic             respExc
);

    //------------------------------------------------------------------
    // Request transmit
    //------------------------------------------------------------------
    typedef enum logic [1:0] {
        MS_IDLE = 2'b01,
        MS_SEND = 2'b10
    } mrc_mst_st_t;

    mrc_mst_st_t stateQ;
    logic [3:0]  idxQ;
    logic [7:0]  slaveQ;
    logic [7:0]  funcQ;
    logic [15:0] wordAQ;
    logic [15:0] wordBQ;
    logic [15:0] txCrcQ;
    logic        txValidQ;
    logic [7:0]  txDataQ;
    logic        txLastQ;
    logic [7:0]  nextByte;

    // Request bytes: address, function, two words high first, then check
    always_comb
    begin
        case (idxQ)
            4'h0:    nextByte = slaveQ;
            4'h1:    nextByte = funcQ;
            4'h2:    nextByte = wordAQ[15:8];
            4'h3:    nextByte = wordAQ[7:0];
            4'h4:    nextByte = wordBQ[15:8];
            4'h5:    nextByte = wordBQ[7:0];
            4'h6:    nextByte = txCrcQ[7:0];
            default: nextByte = txCrcQ[15:8];
        endcase
    end

    // Sender sequencer and link outputs
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            stateQ   <= MS_IDLE;
            idxQ     <= 4'h0;
            slaveQ   <= 8'h00;
            funcQ    <= 8'h00;
            wordAQ   <= 16'h0000;
            wordBQ   <= 16'h0000;
            txCrcQ   <= CRC_PRESET;
            txValidQ <= 1'b0;
            txDataQ  <= 8'h00;
            txLastQ  <= 1'b0;
        end
        else
        begin
            txValidQ <= 1'b0;
            txLastQ  <= 1'b0;
            case (stateQ)
                MS_IDLE:
                begin
                    idxQ   <= 4'h0;
                    txCrcQ <= CRC_PRESET;
                    if (reqGo)
                    begin
                        slaveQ <= reqSlave;
                        funcQ  <= reqFunc;
                        wordAQ <= reqWordA;
                        wordBQ <= reqWordB;
                        stateQ <= MS_SEND;
                    end
                end
                MS_SEND:
                begin
                    txValidQ <= 1'b1;
                    txDataQ  <= nextByte;
                    idxQ     <= idxQ + 4'h1;
                    if (idxQ <= MST_DATA_END)
                        txCrcQ <= mrc_crc_byte(txCrcQ, nextByte);
                    if (idxQ == REQ_LAST_IDX)
                    begin
                        txLastQ <= 1'b1;
                        stateQ  <= MS_IDLE;
                    end
                end
                default:
                begin
                    stateQ <= MS_IDLE;
                end
            endcase
        end
    end

    //------------------------------------------------------------------
    // Response check
    //------------------------------------------------------------------
    logic [15:0] rxCrcQ;
    logic [15:0] rxPrevQ;
    logic [7:0]  rxLastByteQ;
    logic [3:0]  rxCntQ;
    logic [7:0]  rxFuncQ;
    logic        rbValidQ;
    logic [7:0]  rbByteQ;
    logic        doneQ;
    logic        okQ;
    logic        excQ;

    // Runs the CRC over every response byte but the last and checks the carried value
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            rxCrcQ      <= CRC_PRESET;
            rxPrevQ     <= CRC_PRESET;
            rxLastByteQ <= 8'h00;
            rxCntQ      <= 4'h0;
            rxFuncQ     <= 8'h00;
            rbValidQ    <= 1'b0;
            rbByteQ     <= 8'h00;
            doneQ       <= 1'b0;
            okQ         <= 1'b0;
            excQ        <= 1'b0;
        end
        else
        begin
            rbValidQ <= link.sValid;
            rbByteQ  <= link.sValid ? link.sData : 8'h00;
            doneQ    <= link.sValid && link.sLast;
            if (link.sValid)
            begin
                rxLastByteQ <= link.sData;
                if (rxCntQ == 4'h1)
                    rxFuncQ <= link.sData;
                if (rxCntQ != 4'hf)
                    rxCntQ <= rxCntQ + 4'h1;
                if (link.sLast)
                begin
                    okQ     <= (rxPrevQ == {link.sData, rxLastByteQ}) && (rxCntQ >= 4'h3);
                    excQ    <= (rxFuncQ & FN_EXC_BIT) != 8'h00;
                    rxCrcQ  <= CRC_PRESET;
                    rxPrevQ <= CRC_PRESET;
                    rxCntQ  <= 4'h0;
                end
                else
                begin
                    rxPrevQ <= rxCrcQ;
                    rxCrcQ  <= mrc_crc_byte(rxCrcQ, link.sData);
                end
            end
        end
    end

    assign link.mValid   = txValidQ;
    assign link.mData    = txDataQ;
    assign link.mLast    = txLastQ;
    assign busy          = stateQ[1]; // Send state flop
    assign respByteValid = rbValidQ;
    assign respByte      = rbByteQ;
    assign respDone      = doneQ;
    assign respOk        = okQ;
    assign respExc       = excQ;

endmodule : mrc_master_end

/* mrc_ref_crc.svh */
`ifndef MRC_REF_CRC_SVH
`define MRC_REF_CRC_SVH
// Reference CRC step: fold one byte, then eight shifts
function automatic logic [15:0] mrc_ref_crc(input logic [15:0] a, input logic [7:0] b);
    logic [15:0] c;
    c = a ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
endfunction : mrc_ref_crc
`endif

/* mrc_link_checker.sv */
`timescale 1ns/1ns
//----
// Byte link checker
//----
`include "mrc_ref_crc.svh"
module mrc_link_checker
    import mrc_pkg::*;
(
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       rst,
    // Master bytes
    input wire logic       mValid,
    input wire logic [7:0] mData,
    input wire logic       mLast,
    // Slave bytes
    input wire logic       sValid,
    input wire logic [7:0] sData,
    input wire logic       sLast
);
    logic [15:0] mAcc_q, sAcc_q;
    logic [3:0]  mCnt_q;
    logic [5:0]  sCnt_q;
    logic [7:0]  rqA_q, rqF_q;

    // Master frame CRC and count
    always_ff @(posedge core_clk)
    begin
        if (rst || (mValid && mLast))
        begin
            mAcc_q <= 16'hffff;
            mCnt_q <= 4'h0;
        end
        else if (mValid)
        begin
            mAcc_q <= mrc_ref_crc(mAcc_q, mData);
            mCnt_q <= mCnt_q + 4'h1;
        end
    end

    // Slave frame CRC and count
    always_ff @(posedge core_clk)
    begin
        if (rst || (sValid && sLast))
        begin
            sAcc_q <= 16'hffff;
            sCnt_q <= 6'h00;
        end
        else if (sValid)
        begin
            sAcc_q <= mrc_ref_crc(sAcc_q, sData);
            sCnt_q <= sCnt_q + 6'h01;
        end
    end

    // Address and function of the last request
    always_ff @(posedge core_clk)
    begin
        if (mValid && mCnt_q == 4'h0)
            rqA_q <= mData;
        if (mValid && mCnt_q == 4'h1)
            rqF_q <= mData;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_mframe_len: assert property (mLast |-> mValid && mCnt_q == 4'h7)
        else $error("request not eight bytes");
    a_mframe_crc: assert property (mValid && mLast |-> mrc_ref_crc(mAcc_q, mData) == 16'h0000)
        else $error("request check bytes wrong");
    a_sframe_crc: assert property (sValid && sLast |-> mrc_ref_crc(sAcc_q, sData) == 16'h0000)
        else $error("response check bytes wrong");
    a_answer_gap: assert property (mValid && mLast |=> !sValid)
        else $error("answer before check");
    a_bcast_quiet: assert property (mValid && mLast && rqA_q == ADDR_BCAST |=> !sValid [*8])
        else $error("broadcast answered");
    a_resp_addr: assert property (sValid && sCnt_q == 6'h00 |-> sData == rqA_q)
        else $error("response address wrong");
    a_resp_func: assert property (sValid && sCnt_q == 6'h01 |-> (sData & 8'h7f) == rqF_q)
        else $error("response function wrong");
    a_exc_code: assert property (sValid && sCnt_q == 6'h01 && sData[7]
        |=> sValid && (sData == ERR_FUNC || sData == ERR_QTY))
        else $error("bad error code");
    a_read_count: assert property (sValid && sCnt_q == 6'h01 && sData == FN_READ
        |=> sValid && !sData[0] && sData >= 8'h02 && sData <= 8'h20)
        else $error("bad byte count");
endmodule : mrc_link_checker

/* tb_top.sv */
`timescale 1ns/1ns
//----
// Bench: master and slave ends on one link
//----
`include "mrc_ref_crc.svh"
module tb_top
    import mrc_pkg::*;
;
    logic        core_clk, rst, reqGo, busy, respDone, respOk, respExc, cmdOk, crcBad2, rbValid;
    logic [7:0]  reqSlave, reqFunc, ownAddr, rbByte;
    logic [15:0] reqWordA, reqWordB, regAddr, regData, w;
    logic [7:0]  mQ[$], sQ[$], s2Q[$], exp[$], rQ[$];
    logic [15:0] qty[5] = '{16'h0004, 16'h0001, 16'h0010, 16'h0011, 16'h0000};
    int          bad_count, check_count, okCnt, bad2Cnt, k, j;
    mrc_link_if  link ();
    mrc_link_if  link2 ();

    // Design ends; second slave fed by the bench
    mrc_master_end mrc_master_end_inst (.core_clk(core_clk), .rst(rst), .link(link.master),
        .reqGo(reqGo), .reqSlave(reqSlave), .reqFunc(reqFunc), .reqWordA(reqWordA),
        .reqWordB(reqWordB), .busy(busy), .respByteValid(rbValid), .respByte(rbByte),
        .respDone(respDone), .respOk(respOk), .respExc(respExc));
    mrc_slave_end mrc_slave_end_inst (.core_clk(core_clk), .rst(rst), .link(link.slave),
        .ownAddr(ownAddr), .regAddr(regAddr), .regData(regData), .cmdOk(cmdOk), .crcBad());
    mrc_slave_end mrc_slave_end_inst2 (.core_clk(core_clk), .rst(rst), .link(link2.slave),
        .ownAddr(8'h01), .regAddr(), .regData(16'h0000), .cmdOk(), .crcBad(crcBad2));
    mrc_link_checker mrc_link_checker_inst (.core_clk(core_clk), .rst(rst),
        .mValid(link.mValid), .mData(link.mData), .mLast(link.mLast),
        .sValid(link.sValid), .sData(link.sData), .sLast(link.sLast));

    // Clock
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Register stand-in with one cycle latency; link monitors
    always @(posedge core_clk)
    begin
        regData <= {regAddr[7:0] ^ 8'h3c, regAddr[7:0]};
        if (link.mValid === 1'b1)
            mQ.push_back(link.mData);
        if (link.sValid === 1'b1)
            sQ.push_back(link.sData);
        if (link2.sValid === 1'b1)
            s2Q.push_back(link2.sData);
        if (rbValid === 1'b1)
            rQ.push_back(rbByte);
        okCnt += int'(cmdOk === 1'b1);
        bad2Cnt += int'(crcBad2 === 1'b1);
    end

    //----
    // Tasks
    //----
    task automatic cmpV(input logic [15:0] got, input logic [15:0] want);
        check_count++;
        if (got !== want)
        begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : cmpV

    task automatic cmpQ(ref logic [7:0] got[$], ref logic [7:0] want[$]);
        cmpV(16'(got.size()), 16'(want.size()));
        foreach (want[i])
            cmpV((i < got.size()) ? got[i] : 8'hxx, want[i]);
    endtask : cmpQ

    // Append check bytes, low byte first
    task automatic seal();
        logic [15:0] c;
        c = 16'hffff;
        foreach (exp[i])
            c = mrc_ref_crc(c, exp[i]);
        exp.push_back(c[7:0]);
        exp.push_back(c[15:8]);
    endtask : seal

    // One request through the master end, bounded wait for the answer
    task automatic request(input logic [7:0] sl, fn, input logic [15:0] a, b, input int lim);
        int i;
        mQ.delete();
        sQ.delete();
        rQ.delete();
        @(negedge core_clk);
        reqGo = 1'b1;
        reqSlave = sl;
        reqFunc = fn;
        reqWordA = a;
        reqWordB = b;
        @(negedge core_clk);
        reqGo = 1'b0;
        for (i = 0; i < lim && respDone !== 1'b1; i++)
            @(negedge core_clk);
        @(posedge core_clk) #1;
    endtask : request

    // Raw frame into the second slave, back to back
    task automatic sendRaw();
        foreach (exp[i])
        begin
            @(negedge core_clk);
            {link2.mValid, link2.mData, link2.mLast} = {1'b1, exp[i], i == exp.size() - 1};
        end
        @(negedge core_clk);
        {link2.mValid, link2.mLast} = 2'b00;
        link2.mData = ~link2.mData;  // Released line shows the inverse
        s2Q.delete();
        repeat (40) @(negedge core_clk);
    endtask : sendRaw

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize

    //----
    // Tests
    //----
    initial
    begin
        {rst, reqGo, reqSlave, reqFunc, reqWordA, reqWordB} = {1'b1, 49'h0};
        {ownAddr, bad_count, check_count, okCnt, bad2Cnt} = {8'h02, 128'h0};
        {link2.mValid, link2.mData, link2.mLast} = 10'h0;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        // Reads: normal, one, sixteen, seventeen and zero words
        foreach (qty[k])
        begin
            request(8'h02, FN_READ, 16'h0020, qty[k], 700);
            exp = '{8'h02, 8'h03, 8'h00, 8'h20, 8'h00, 8'h04, 8'h45, 8'hf0};
            if (k == 0)
                cmpQ(mQ, exp);
            exp = '{8'h02, 8'h83, 8'h03, 8'hf1, 8'h31};
            if (qty[k] != 16'h0000 && qty[k] <= MAX_QTY)
            begin
                exp = '{8'h02, FN_READ, qty[k][6:0] << 1};
                for (j = 0; j < qty[k]; j++)
                begin
                    w = 16'h0020 + 16'(j);
                    exp.push_back(w[7:0] ^ 8'h3c);
                    exp.push_back(w[7:0]);
                end
                seal();
            end
            cmpQ(sQ, exp);
            cmpQ(rQ, sQ);
            cmpV({respOk, respExc}, {1'b1, qty[k] == 0 || qty[k] > MAX_QTY});
        end
        // Loopback with two test code and data pairs
        ownAddr = 8'h01;
        for (k = 0; k < 2; k++)
        begin
            w = k ? 16'h0001 : 16'ha537;
            request(8'h01, FN_LOOP, k ? 16'hffff : 16'h0000, w, 700);
            exp = '{8'h01, FN_LOOP, {8{k[0]}}, {8{k[0]}}, w[15:8], w[7:0]};
            seal();
            cmpQ(mQ, exp);
            cmpQ(sQ, mQ);
        end
        // Unknown function
        request(8'h01, 8'h05, 16'h0000, 16'h0001, 700);
        exp = '{8'h01, 8'h85, ERR_FUNC};
        seal();
        cmpQ(sQ, exp);
        cmpV(respExc, 1'b1);
        // Broadcast and foreign address: never answered
        for (k = 0; k < 3; k++)
        begin
            j = okCnt;
            request(k == 2 ? 8'h07 : 8'h00, k ? FN_READ : FN_LOOP, 16'h0000, 16'h0001, 40);
            cmpV(16'(sQ.size()), 16'h0000);
            cmpV(16'(okCnt - j), k == 2 ? 16'h0000 : 16'h0001);
        end
        // Second slave: bad check bytes, short loopback, then a good frame
        exp = '{8'h01, FN_LOOP, 8'h12, 8'h34, 8'h56, 8'h78};
        seal();
        exp[7] = exp[7] ^ 8'h01;
        sendRaw();
        cmpV(16'(bad2Cnt), 16'h0001);
        cmpV(16'(s2Q.size()), 16'h0000);
        exp = '{8'h01, FN_LOOP, 8'h12, 8'h34, 8'h56};
        seal();
        sendRaw();
        exp = '{8'h01, 8'h88, ERR_FUNC};
        seal();
        cmpQ(s2Q, exp);
        exp = '{8'h01, FN_LOOP, 8'h12, 8'h34, 8'h56, 8'h78};
        seal();
        sendRaw();
        cmpQ(s2Q, exp);
        summarize();
    end

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        summarize();
    end
endmodule : tb_top
